// ---- verilog/ctmc_cfg.svh ----
`ifndef CTMC_CFG_SVH
`define CTMC_CFG_SVH
// =========================================================
// transceiver mode codes
`define CTMC_TRX_OFF 2'h0
`define CTMC_TRX_WAKE 2'h1
`define CTMC_TRX_NORMAL 2'h3
`define CTMC_TRX_RXONLY 2'h2
// device power mode codes
`define CTMC_DEV_NORMAL 3'h0
`define CTMC_DEV_STOP 3'h1
`define CTMC_DEV_SLEEP 3'h2
`define CTMC_DEV_RESTART 3'h3
`define CTMC_DEV_FAILSAFE 3'h4
// termination codes
`define CTMC_TERM_FLOAT 2'h0
`define CTMC_TERM_HALF 2'h1
`define CTMC_TERM_GND 2'h2
`define CTMC_TERM_2V5 2'h3
// times in ns and derived cycle counts at 25 ns
`define CTMC_CLK_NS 25
`define CTMC_T_EN_NS 20000
`define CTMC_WAKE_TIME_MIN_NS 500
`define CTMC_WAKE_TIME_MAX_NS 2000000
`define CTMC_T_SIL_NS 1000000
`define CTMC_T_TXTO_NS 2000000
`define CTMC_EN_CYC ((`CTMC_T_EN_NS + `CTMC_CLK_NS - 1) / `CTMC_CLK_NS)
`define CTMC_WAKE1_CYC ((`CTMC_WAKE_TIME_MIN_NS + `CTMC_CLK_NS - 1) / `CTMC_CLK_NS)
`define CTMC_WAKE2_CYC (`CTMC_WAKE_TIME_MAX_NS / `CTMC_CLK_NS)
`define CTMC_SIL_CYC (`CTMC_T_SIL_NS / `CTMC_CLK_NS)
`define CTMC_TXTO_CYC (`CTMC_T_TXTO_NS / `CTMC_CLK_NS)
// fifo shape
`define CTMC_FIFO_W 1
`define CTMC_FIFO_D 16
`endif

// ---- verilog/ctmc_pkg.sv ----
package ctmc_pkg;
  typedef enum logic [4:0] {
    CTMC_WAIT = 5'h01,
    CTMC_D1 = 5'h02,
    CTMC_R1 = 5'h04,
    CTMC_D2 = 5'h08,
    CTMC_DONE = 5'h10
  } ctmc_wup_t;
endpackage

// ---- verilog/ctmc_fifo.sv ----
// the sample fifo sits in ctmc_top.sv beside the receive path that feeds it

// ---- verilog/ctmc_top.sv ----
`timescale 1ns/1ps
`include "ctmc_cfg.svh"
module ctmc_top import ctmc_pkg::*; #(
  parameter int EN_CYC = `CTMC_EN_CYC,
  parameter int WAKE1_CYC = `CTMC_WAKE1_CYC,
  parameter int WAKE2_CYC = `CTMC_WAKE2_CYC,
  parameter int SIL_CYC = `CTMC_SIL_CYC,
  parameter int TXTO_CYC = `CTMC_TXTO_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] trx_mode_req_i,
  input wire logic trx_mode_wr_i,
  input wire logic [2:0] dev_mode_i,
  input wire logic transceiver_supply_uv_i,
  input wire logic watchdog_on_bus_wake_i,
  input wire logic wd_disabled_i,
  input wire logic bus_wake_clr_i,
  input wire logic bus_fault_clr_i,
  input wire logic tx_data_in_i,
  input wire logic bus_dom_i,
  input wire logic rx_fifo_ready_i,
  output logic [1:0] trx_mode_o,
  output logic drv_dom_o,
  output logic rx_data_out_o,
  output logic rx_sample_o,
  output logic rx_sample_valid_o,
  output logic rx_overflow_o,
  output logic interrupt_out_low_o,
  output logic bus_wake_flag_o,
  output logic bus_fault_flag_o,
  output logic wd_enable_req_o,
  output logic restart_req_o,
  output logic [1:0] term_o
);
  // =========================================================
  // mode register
  logic [1:0] mode_q;
  logic [2:0] dev_q;
  logic dev_started_q;
  wire dev_normal = (dev_mode_i == `CTMC_DEV_NORMAL);
  wire dev_stop = (dev_mode_i == `CTMC_DEV_STOP);
  wire dev_sleep = (dev_mode_i == `CTMC_DEV_SLEEP);
  wire dev_fs = (dev_mode_i == `CTMC_DEV_FAILSAFE);
  wire act_ok = dev_normal || dev_stop; // normal and rx-only allowed here
  wire req_act = (trx_mode_req_i == `CTMC_TRX_NORMAL) || (trx_mode_req_i == `CTMC_TRX_RXONLY);
  wire req_wake = (trx_mode_req_i == `CTMC_TRX_WAKE);
  wire req_ok = trx_mode_wr_i && ((req_act && act_ok) || (req_wake && !dev_fs) ||
                (trx_mode_req_i == `CTMC_TRX_OFF));
  wire dev_chg = dev_started_q && (dev_q != dev_mode_i);
  wire rearm_dev = dev_chg && (dev_stop || dev_sleep || dev_fs);
  wire fs_force = dev_fs && (mode_q != `CTMC_TRX_WAKE);
  wire mode_wr = fs_force || (req_ok && (trx_mode_req_i != mode_q));
  wire [1:0] mode_d = fs_force ? `CTMC_TRX_WAKE : trx_mode_req_i;
  wire in_normal = (mode_q == `CTMC_TRX_NORMAL);
  wire in_rxonly = (mode_q == `CTMC_TRX_RXONLY);
  wire in_wake = (mode_q == `CTMC_TRX_WAKE);
  // requests outside the allowed power modes are dropped silently
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= `CTMC_TRX_OFF;
      dev_q <= `CTMC_DEV_NORMAL;
      dev_started_q <= 1'b0;
    end else begin
      if (mode_wr) mode_q <= mode_d;
      dev_q <= dev_mode_i;
      dev_started_q <= 1'b1;
    end
  end
  assign trx_mode_o = mode_q;
  // =========================================================
  // enable timer and early dominant suppression
  logic [31:0] en_cnt_q;
  logic en_done_q;
  logic tx_gate_q;
  wire tx_dom = !tx_data_in_i;
  // a dominant seen before enabling completes blocks until tx goes recessive
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_cnt_q <= '0;
      en_done_q <= 1'b0;
      tx_gate_q <= 1'b0;
    end else if (!in_normal || mode_wr) begin
      en_cnt_q <= '0;
      en_done_q <= 1'b0;
      tx_gate_q <= 1'b0;
    end else begin
      if (!en_done_q) en_cnt_q <= en_cnt_q + 32'h1;
      if (en_cnt_q == EN_CYC - 1) en_done_q <= 1'b1;
      if (en_done_q && !tx_dom) tx_gate_q <= 1'b1;
    end
  end
  // =========================================================
  // transmit dominant time-out
  logic [31:0] to_cnt_q;
  logic to_act_q;
  logic fault_q;
  wire to_hit = in_normal && tx_dom && (to_cnt_q == TXTO_CYC - 1);
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      to_cnt_q <= '0;
      to_act_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      if (in_normal && tx_dom && !to_act_q) to_cnt_q <= to_cnt_q + 32'h1;
      else to_cnt_q <= '0;
      if (to_hit) to_act_q <= 1'b1;
      else if (!tx_dom || !in_normal) to_act_q <= 1'b0;
      if (to_hit) fault_q <= 1'b1; // set wins over clear
      else if (bus_fault_clr_i) fault_q <= 1'b0;
    end
  end
  assign bus_fault_flag_o = fault_q;
  // driver dominant only when enabled, ungated and not timed out
  assign drv_dom_o = in_normal && tx_gate_q && !to_act_q && tx_dom;
  // =========================================================
  // wake pattern detector
  ctmc_wup_t wst_q;
  logic [31:0] ph_cnt_q;
  logic armed_q;
  logic woke_q;
  wire ph_ok = (ph_cnt_q >= WAKE1_CYC) && (ph_cnt_q < WAKE2_CYC);
  wire ph_long = (ph_cnt_q >= WAKE2_CYC);
  wire det_on = in_wake && armed_q && !mode_wr;
  wire wake_hit = det_on && (wst_q == CTMC_D2) && !bus_dom_i && ph_ok;
  ctmc_wup_t wst_d;
  always_comb begin
    wst_d = wst_q;
    unique case (wst_q)
      CTMC_WAIT: if (bus_dom_i) wst_d = CTMC_D1;
      // an over-long dominant stays put until it ends, so it is never re-counted short
      CTMC_D1: if (!bus_dom_i) wst_d = ph_ok ? CTMC_R1 : CTMC_WAIT;
      CTMC_R1: if (bus_dom_i) wst_d = (ph_ok && ph_cnt_q != WAKE1_CYC) ? CTMC_D2 : CTMC_D1;
        else if (ph_long) wst_d = CTMC_WAIT;
      CTMC_D2: if (!bus_dom_i) wst_d = ph_ok ? CTMC_DONE : CTMC_WAIT;
      CTMC_DONE: wst_d = CTMC_DONE;
      default: wst_d = CTMC_WAIT;
    endcase
  end
  // phase counter restarts on each state change
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wst_q <= CTMC_WAIT;
      ph_cnt_q <= '0;
    end else if (!det_on) begin
      wst_q <= CTMC_WAIT;
      ph_cnt_q <= '0;
    end else begin
      wst_q <= wst_d;
      ph_cnt_q <= (wst_d != wst_q) ? 32'h1 : ph_cnt_q + 32'h1;
    end
  end
  // arming: cleared by a wake, set by leaving wake mode or a power change into stop, sleep or fail-safe
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      armed_q <= 1'b1;
      woke_q <= 1'b0;
    end else begin
      if (wake_hit) armed_q <= 1'b0;
      else if (rearm_dev || (!in_wake)) armed_q <= 1'b1;
      if (wake_hit) woke_q <= 1'b1;
      else if (mode_wr || rearm_dev) woke_q <= 1'b0;
    end
  end
  // =========================================================
  // wake reactions
  logic flag_q;
  logic int_q;
  logic wd_q;
  logic rst_req_q;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_q <= 1'b0;
      int_q <= 1'b0;
      wd_q <= 1'b0;
      rst_req_q <= 1'b0;
    end else begin
      if (wake_hit) flag_q <= 1'b1;
      else if (bus_wake_clr_i) flag_q <= 1'b0;
      if (wake_hit && (dev_stop || dev_normal)) int_q <= 1'b1;
      else if (bus_wake_clr_i) int_q <= 1'b0;
      wd_q <= wake_hit && dev_stop && watchdog_on_bus_wake_i && wd_disabled_i;
      rst_req_q <= wake_hit && (dev_sleep || dev_fs);
    end
  end
  assign bus_wake_flag_o = flag_q;
  assign interrupt_out_low_o = !int_q;
  assign wd_enable_req_o = wd_q;
  assign restart_req_o = rst_req_q;
  // =========================================================
  // receive path: level plus a buffered sample stream
  logic rx_q;
  logic ovf_q;
  wire rx_live = (in_normal || in_rxonly) ? !bus_dom_i : 1'b1;
  wire fifo_in_ready;
  wire sample_push = (in_normal || in_rxonly) && (rx_q != rx_live);
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_q <= 1'b1;
      ovf_q <= 1'b0;
    end else begin
      rx_q <= (woke_q || wake_hit) ? 1'b0 : rx_live;
      if (sample_push && !fifo_in_ready) ovf_q <= 1'b1;
      else if (!in_normal && !in_rxonly) ovf_q <= 1'b0;
    end
  end
  assign rx_data_out_o = rx_q;
  assign rx_overflow_o = ovf_q;
  // edges are queued for a slow reader; an edge that meets a full fifo is dropped and sets rx_overflow_o
  ctmc_fifo #(
    .W(`CTMC_FIFO_W),
    .D(`CTMC_FIFO_D)
  ) u_ctmc_fifo (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(rx_live),
    .in_valid_i(sample_push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(rx_sample_o),
    .out_valid_o(rx_sample_valid_o),
    .out_ready_i(rx_fifo_ready_i)
  );
  // =========================================================
  // termination select
  logic [31:0] sil_cnt_q;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) sil_cnt_q <= '0;
    else if (!in_wake || mode_wr) sil_cnt_q <= '0;
    else if (sil_cnt_q != SIL_CYC) sil_cnt_q <= sil_cnt_q + 32'h1;
  end
  wire sil_done = (sil_cnt_q == SIL_CYC);
  logic [1:0] term_q;
  wire [1:0] term_d = in_normal ? `CTMC_TERM_HALF :
                      in_rxonly ? (transceiver_supply_uv_i ? `CTMC_TERM_2V5 : `CTMC_TERM_HALF) :
                      in_wake ? (woke_q ? `CTMC_TERM_2V5 :
                                 (sil_done ? `CTMC_TERM_GND : `CTMC_TERM_FLOAT)) :
                      `CTMC_TERM_FLOAT;
  // termination leaves through a flop; one cycle late is far below any bus timing
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) term_q <= `CTMC_TERM_FLOAT;
    else term_q <= term_d;
  end
  assign term_o = term_q;
  // =========================================================
  // checks
  off_no_wake_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (mode_q == `CTMC_TRX_OFF) |=> !$rose(bus_wake_flag_o))
    else $error("wake flag raised in off mode");
  drv_idle_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !in_normal |-> !drv_dom_o)
    else $error("driver active outside normal");
  en_guard_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    in_normal && !en_done_q |-> !drv_dom_o)
    else $error("driver active before enabling time");
  wake_rx_low_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_hit |=> !rx_data_out_o)
    else $error("rx not low after wake");
  wake_mode_kept_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_hit && !fs_force |=> trx_mode_o == `CTMC_TRX_WAKE)
    else $error("mode changed");
  flag_set_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_hit |=> bus_wake_flag_o)
    else $error("wake flag not set");
  stop_irq_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_hit && dev_stop |=> !interrupt_out_low_o && bus_wake_flag_o)
    else $error("stop wake not signalled");
  wd_pulse_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_hit && dev_stop && watchdog_on_bus_wake_i && wd_disabled_i |=> wd_enable_req_o)
    else $error("watchdog not requested");
  sleep_no_irq_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_hit && dev_sleep && interrupt_out_low_o |=> interrupt_out_low_o && restart_req_o)
    else $error("sleep wake wrong");
  restart_pulse_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wake_hit && (dev_sleep || dev_fs) |=> restart_req_o)
    else $error("restart not requested");
  short_phase_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wst_q == CTMC_D2) && !bus_dom_i && (ph_cnt_q < WAKE1_CYC) |=> !$rose(bus_wake_flag_o))
    else $error("short dominant taken as wake");
  rearm_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    rearm_dev && !wake_hit |=> armed_q)
    else $error("power change did not rearm");
  timeout_fault_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    to_hit |=> !drv_dom_o && bus_fault_flag_o)
    else $error("timeout not handled");
  to_release_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    in_normal && to_act_q && !tx_dom |=> !to_act_q)
    else $error("transmitter not released");
  normal_allowed_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $changed(mode_q) && in_normal |-> $past(act_ok))
    else $error("normal in bad mode");
  fs_force_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (dev_fs && !trx_mode_wr_i) ##1 dev_fs |-> in_wake)
    else $error("fail-safe not wake mode");
  rx_only_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    in_rxonly && !woke_q |=> rx_data_out_o != $past(bus_dom_i))
    else $error("rx does not follow bus");
  term_normal_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    in_normal && $stable(mode_q) |-> term_o == `CTMC_TERM_HALF)
    else $error("normal termination wrong");
  term_sil_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    in_wake && !sil_done |=> term_o != `CTMC_TERM_GND)
    else $error("ground termination too early");
endmodule // ctmc_top

// =========================================================
// small stream fifo with honest full and empty
module ctmc_fifo #(
  parameter int W = 1,
  parameter int D = 16
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_q != D[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
  // storage has no reset, only pointers do
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
  // pointers and occupancy
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
  fifo_full_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !in_ready_o && !out_ready_i |=> !in_ready_o)
    else $error("full fifo lost its content");
endmodule // ctmc_fifo

// ---- tb/ctmc_ctrl_model.sv ----
`timescale 1ns/1ps
// =========================================================
// protocol controller model: drives transmit data only
module ctmc_ctrl_model (
  input wire logic send_dom_i,
  output logic tx_data_o
);
  // idle line is recessive; follows the bench's falling-edge request
  assign tx_data_o = ~send_dom_i;
endmodule // ctmc_ctrl_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "ctmc_cfg.svh"
module testbench;
  localparam int EN = 8;
  localparam int SIL = 16;
  localparam int TO = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mreq = 2'h0;
  logic mwr = 1'b0;
  logic [2:0] dev = 3'h0;
  logic uv = 1'b0;
  logic wob = 1'b1;
  logic wdd = 1'b1;
  logic wclr = 1'b0;
  logic fclr = 1'b0;
  logic send_dom = 1'b0;
  logic ext_dom = 1'b0;
  logic fready = 1'b1;
  logic tx, bus_dom, drv, rx, smp, smp_v, ovf, interrupt_out_low, wflag, fflag, wdreq, rsreq;
  logic [1:0] mode, term;
  int n_fail = 0;
  int samples_checked = 0;
  int wd_seen = 0;
  int rs_seen = 0;
  int drained = 0;
  int drained_lo = 0;
  // =========================================================
  // design, controller and bus
  assign bus_dom = ext_dom | drv; // wired-or: any dominant wins
  ctmc_ctrl_model u_ctmc_ctrl_model (.send_dom_i(send_dom), .tx_data_o(tx));
  ctmc_top #(.EN_CYC(EN), .WAKE1_CYC(4), .WAKE2_CYC(40), .SIL_CYC(SIL), .TXTO_CYC(TO))
  u_ctmc_top (.sys_clk_i(clk), .sys_rst_i(rst), .trx_mode_req_i(mreq), .trx_mode_wr_i(mwr),
    .dev_mode_i(dev), .transceiver_supply_uv_i(uv), .watchdog_on_bus_wake_i(wob), .wd_disabled_i(wdd),
    .bus_wake_clr_i(wclr), .bus_fault_clr_i(fclr), .tx_data_in_i(tx), .bus_dom_i(bus_dom),
    .rx_fifo_ready_i(fready), .trx_mode_o(mode), .drv_dom_o(drv), .rx_data_out_o(rx),
    .rx_sample_o(smp), .rx_sample_valid_o(smp_v), .rx_overflow_o(ovf),
    .interrupt_out_low_o(interrupt_out_low), .bus_wake_flag_o(wflag), .bus_fault_flag_o(fflag),
    .wd_enable_req_o(wdreq), .restart_req_o(rsreq), .term_o(term));
  initial forever #12.5 clk = ~clk;
  // one-cycle pulses are counted so that no later check can miss them
  always @(posedge clk) begin
    if (wdreq === 1'b1) wd_seen++;
    if (rsreq === 1'b1) rs_seen++;
    if (smp_v === 1'b1 && fready) drained++;
    if (smp_v === 1'b1 && fready && smp === 1'b0) drained_lo++;
  end
  // =========================================================
  // access tasks
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [1:0] m);
    mreq = m;
    mwr = 1'b1;
    cyc(1);
    mwr = 1'b0;
    cyc(2);
  endtask
  // two dominant phases around one recessive gap, lengths in cycles
  task automatic wake_pattern(input int d1, input int r, input int d2);
    ext_dom = 1'b1;
    cyc(d1);
    ext_dom = 1'b0;
    cyc(r);
    ext_dom = 1'b1;
    cyc(d2);
    ext_dom = 1'b0;
    cyc(4);
  endtask
  task automatic pulse_clr();
    wclr = 1'b1;
    cyc(1);
    wclr = 1'b0;
    cyc(2);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // =========================================================
  // hang guard, far longer than the whole sequence
  initial begin
    cyc(20000);
    n_fail++;
    results();
  end
  // =========================================================
  // test sequence
  initial begin
    cyc(20);
    chk("mode", mode, 8'h0);
    chk("term", term, 8'h0);
    chk("interrupt_out_low", interrupt_out_low, 8'h1);
    rst = 1'b0;
    cyc(2);
    wake_pattern(10, 10, 10);
    chk("wflag", wflag, 8'h0);
    chk("rx", rx, 8'h1);
    dev = 3'h2;
    wr(2'h3);
    chk("mode", mode, 8'h0);
    $display("test off_mode done");
    // early dominant must be suppressed until recessive seen after enable
    dev = 3'h0;
    wr(2'h3);
    send_dom = 1'b1;
    chk("drv", drv, 8'h0);
    cyc(EN + 2);
    chk("drv", drv, 8'h0);
    chk("term", term, 8'h1);
    send_dom = 1'b0;
    cyc(2);
    send_dom = 1'b1;
    cyc(2);
    chk("drv", drv, 8'h1);
    chk("rx", rx, 8'h0);
    cyc(TO + 5);
    chk("drv", drv, 8'h0);
    chk("fflag", fflag, 8'h1);
    chk("mode", mode, 8'h3);
    send_dom = 1'b0;
    cyc(2);
    send_dom = 1'b1;
    cyc(2);
    chk("drv", drv, 8'h1);
    send_dom = 1'b0;
    fclr = 1'b1;
    cyc(1);
    fclr = 1'b0;
    cyc(2);
    chk("fflag", fflag, 8'h0);
    $display("test normal_mode done");
    // receive-only, then a stalled sample fifo pushed past full
    wr(2'h2);
    send_dom = 1'b1;
    ext_dom = 1'b1;
    cyc(3);
    chk("drv", drv, 8'h0);
    chk("rx", rx, 8'h0);
    uv = 1'b1;
    cyc(1);
    chk("term", term, 8'h3);
    uv = 1'b0;
    send_dom = 1'b0;
    ext_dom = 1'b0;
    cyc(4);
    fready = 1'b0;
    drained = 0;
    drained_lo = 0;
    repeat (20) begin
      ext_dom = ~ext_dom;
      cyc(2);
    end
    chk("ovf", ovf, 8'h1);
    fready = 1'b1;
    cyc(40);
    chk("drained", drained[7:0], 8'h10);
    chk("drained_lo", drained_lo[7:0], 8'h08);
    $display("test rx_only done");
    // wake-capable in stop, silence delay, rearm by mode toggle
    dev = 3'h1;
    wr(2'h1);
    chk("term", term, 8'h0);
    cyc(SIL + 2);
    chk("term", term, 8'h2);
    wake_pattern(2, 10, 10);
    chk("wflag", wflag, 8'h0);
    wake_pattern(10, 10, 10);
    chk("rx", rx, 8'h0);
    chk("wflag", wflag, 8'h1);
    chk("interrupt_out_low", interrupt_out_low, 8'h0);
    chk("mode", mode, 8'h1);
    chk("wd", wd_seen[7:0], 8'h1);
    chk("term", term, 8'h3);
    pulse_clr();
    wake_pattern(10, 10, 10);
    chk("wflag", wflag, 8'h0);
    chk("rx", rx, 8'h0);
    wr(2'h0);
    chk("rx", rx, 8'h1);
    wr(2'h1);
    wake_pattern(10, 10, 10);
    chk("wflag", wflag, 8'h1);
    pulse_clr();
    $display("test wake_stop done");
    // entering sleep rearms; wake there restarts without interrupt
    dev = 3'h2;
    cyc(3);
    wake_pattern(45, 10, 10);
    chk("wflag", wflag, 8'h0);
    chk("restart", rs_seen[7:0], 8'h0);
    wake_pattern(10, 10, 10);
    chk("restart", rs_seen[7:0], 8'h1);
    chk("interrupt_out_low", interrupt_out_low, 8'h1);
    chk("wflag", wflag, 8'h1);
    dev = 3'h0;
    wr(2'h0);
    dev = 3'h4;
    cyc(3);
    chk("mode", mode, 8'h1);
    $display("test wake_sleep done");
    results();
  end
endmodule // testbench
